// *** rtl/tmr16_regs.vh ***
`ifndef TMR16_REGS_VH
`define TMR16_REGS_VH

// Register offsets, one byte each
`define TMR16_CTL2_OFS     8'h00
`define TMR16_CTL1_OFS     8'h01
`define TMR16_STAT_OFS     8'h02
`define TMR16_IC1H_OFS     8'h03
`define TMR16_IC1L_OFS     8'h04
`define TMR16_CNTH_OFS     8'h08
`define TMR16_CNTL_OFS     8'h09
`define TMR16_ACNTH_OFS    8'h0a
`define TMR16_ACNTL_OFS    8'h0b
`define TMR16_IC2H_OFS     8'h0c
`define TMR16_IC2L_OFS     8'h0d

// First control register fields
`define TMR16_CTL1_CAPIE   7
`define TMR16_CTL1_OVFIE   5
`define TMR16_CTL1_EDGE1   1

// Second control register fields
`define TMR16_CTL2_OPM     5
`define TMR16_CTL2_PWM     4
`define TMR16_CTL2_CKSEL1  3
`define TMR16_CTL2_CKSEL0  2
`define TMR16_CTL2_EDGE2   1
`define TMR16_CTL2_EXTEDGE 0

// Status register fields
`define TMR16_STAT_CAPF1   7
`define TMR16_STAT_CMPF1   6
`define TMR16_STAT_OVF     5
`define TMR16_STAT_CAPF2   4
`define TMR16_STAT_CMPF2   3

// Clock select codes
`define TMR16_CKSEL_DIV4   2'h0
`define TMR16_CKSEL_DIV2   2'h1
`define TMR16_CKSEL_DIV8   2'h2
`define TMR16_CKSEL_EXT    2'h3

// Reset values and counter maximum
`define TMR16_CTL_RST      8'h00
`define TMR16_CNT_RST      16'hfffc
`define TMR16_CNT_MAX      16'hffff
`define TMR16_ZERO16       16'h0000

// Least CPU edges between two external active edges
`define TMR16_EXT_MIN_EDGES 4

`endif

// *** rtl/tmr16_capture.v ***
`timescale 1ns/10ps
`include "tmr16_regs.vh"

module tmr16_capture (
  // Clock and reset
  input  wire        clk,
  input  wire        rst_n,
  // Pin and setup
  input  wire        cap_pin,
  input  wire        edge_rise,
  input  wire        chan_on,
  input  wire [15:0] cnt_val,
  // Register accesses
  input  wire        stat_rd,
  input  wire        hi_rd,
  input  wire        lo_rd,
  input  wire        lo_acc,
  // State
  output reg  [15:0] cap_val_r,
  output reg         flag_r
);

  reg  pin_prev_r;
  reg  inhib_r;
  reg  arm_r;
  wire pin_edge;
  wire hit;

  // Pin always wired in, output-driven pins too
  assign pin_edge = edge_rise ? (cap_pin & ~pin_prev_r)
                              : (~cap_pin & pin_prev_r);
  assign hit = chan_on & ~inhib_r & pin_edge;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_prev_r <= 1'b0;
      inhib_r    <= 1'b0;
      arm_r      <= 1'b0;
      flag_r     <= 1'b0;
      cap_val_r  <= `TMR16_ZERO16;
    end else begin
      pin_prev_r <= cap_pin;
      // High read freezes the pair until the low read
      if (hi_rd)
        inhib_r <= 1'b1;
      else if (lo_rd)
        inhib_r <= 1'b0;
      if (hit)
        cap_val_r <= cnt_val;
      if (stat_rd && flag_r)
        arm_r <= 1'b1;
      else if (lo_acc)
        arm_r <= 1'b0;
      // Set beats a clear in the same cycle
      if (hit)
        flag_r <= 1'b1;
      else if (lo_acc && arm_r)
        flag_r <= 1'b0;
    end
  end

endmodule

// *** rtl/tmr16_top.v ***
// How it works
// - Internal tick is CPU clock divided by 2, 4 or 8 per clock select.
// - Counter loads FFFC at reset and on any counter low byte write.
// - Main and alternate pairs show one value; alternate low never clears overflow.
// - High byte read buffers the low byte for the next low read.
// - Buffered low byte holds through repeated high reads until low is read.
// - Outside a sequence a low read returns the live low byte.
// - Overflow flag sets when counter rolls from FFFF to 0000.
// - Overflow interrupt needs its enable and clear CPU mask; stays pending.
// - Overflow flag clears after status read then main low byte access.
// - Counter ignores wait mode and keeps running.
// - Halt freezes counter; interrupt wake resumes, reset wake reloads.
// - Both clock select bits one picks external pin with chosen edge.
// - External edges are synchronised; source spaces them four CPU edges.
// - Active capture edge latches counter into that channel's capture pair.
// - Each channel has its own edge select bit, one per control register.
// - Capture sets channel flag; interrupt gated by enable and CPU mask.
// - One capture interrupt enable gates both channels.
// - Capture flag clears after status read then capture low access.
// - Capture high read blocks captures and flag until low byte read.
// - In one pulse or PWM mode only channel two captures.
// - Capture pins stay connected even when driven as outputs.
// - Flash timer A variant lacks channel two; its flags read zero.
`timescale 1ns/10ps
`include "tmr16_regs.vh"

module tmr16_top #(
  parameter FLASH_TIMER_A = 0
) (
  // Clock and reset
  input  wire        clk,
  input  wire        rst_n,
  // Register port
  input  wire [7:0]  addr,
  input  wire [7:0]  wr_data,
  input  wire        wr_stb,
  input  wire        rd_stb,
  output reg  [7:0]  rd_data,
  // Timer pins
  input  wire        ext_timer_clock_pin,
  input  wire        capture_pin_one,
  input  wire        capture_pin_two,
  // CPU state
  input  wire        cpu_irq_mask,
  input  wire        halt_mode,
  // Results
  output reg         timer_irq,
  output reg  [15:0] count_value
);

  reg  [7:0]  first_control_register_r;
  reg  [7:0]  second_control_register_r;
  reg  [2:0]  div_r;
  reg         ext_prev_r;
  reg         ext_now_r;
  reg         overflow_flag_r;
  reg         ovf_arm_r;
  reg         seq_open_r;
  reg  [7:0]  low_buf_r;
  reg  [7:0]  rd_nxt;
  reg         tick;

  wire [1:0]  timer_clock_select;
  wire        ext_edge;
  wire        cnt_load;
  wire        cnt_step;
  wire        roll;
  wire        stat_rd;
  wire        cnth_rd;
  wire        cntl_rd;
  wire        cntl_acc;
  wire        low_rd;
  wire        high_rd;
  wire        pwm_or_opm;
  wire [1:0]  cap_pin;
  wire [1:0]  cap_edge;
  wire [1:0]  cap_on;
  wire [1:0]  cap_flag;
  wire [15:0] cap_val [0:1];
  wire [7:0]  cap_hi_ofs [0:1];
  wire [7:0]  cap_lo_ofs [0:1];
  wire [7:0]  status;
  wire        irq_nxt;

  assign timer_clock_select =
    second_control_register_r[`TMR16_CTL2_CKSEL1:`TMR16_CTL2_CKSEL0];
  assign pwm_or_opm = second_control_register_r[`TMR16_CTL2_OPM] |
                      second_control_register_r[`TMR16_CTL2_PWM];

  // Register access decode
  assign stat_rd  = rd_stb && (addr == `TMR16_STAT_OFS);
  assign cnth_rd  = rd_stb && (addr == `TMR16_CNTH_OFS);
  assign cntl_rd  = rd_stb && (addr == `TMR16_CNTL_OFS);
  assign cntl_acc = (rd_stb | wr_stb) && (addr == `TMR16_CNTL_OFS);
  assign high_rd  = cnth_rd ||
                    (rd_stb && (addr == `TMR16_ACNTH_OFS));
  assign low_rd   = cntl_rd ||
                    (rd_stb && (addr == `TMR16_ACNTL_OFS));
  assign cnt_load = wr_stb && ((addr == `TMR16_CNTL_OFS) ||
                               (addr == `TMR16_ACNTL_OFS));

  // External pin taken through a register, so one cycle late
  assign ext_edge = second_control_register_r[`TMR16_CTL2_EXTEDGE] ?
                    (ext_now_r & ~ext_prev_r) :
                    (~ext_now_r & ext_prev_r);

  // Tick select
  always @* begin
    case (timer_clock_select)
      `TMR16_CKSEL_DIV2: tick = div_r[0];
      `TMR16_CKSEL_DIV4: tick = &div_r[1:0];
      `TMR16_CKSEL_DIV8: tick = &div_r;
      `TMR16_CKSEL_EXT:  tick = ext_edge;
      default:           tick = 1'b0;
    endcase
  end

  // Wait mode has no input here: nothing slows the count
  assign cnt_step = tick & ~halt_mode;
  assign roll = cnt_step & ~cnt_load &
                (count_value == `TMR16_CNT_MAX);

  // Prescaler and external edge history
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_r      <= 3'h0;
      ext_now_r  <= 1'b0;
      ext_prev_r <= 1'b0;
    end else begin
      ext_now_r  <= ext_timer_clock_pin;
      ext_prev_r <= ext_now_r;
      if (!halt_mode)
        div_r <= div_r + 3'h1;
    end
  end

  // Free-running counter; halt holds the count in place
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      count_value <= `TMR16_CNT_RST;
    else if (cnt_load)
      count_value <= `TMR16_CNT_RST;
    else if (cnt_step)
      count_value <= count_value + 16'h0001;
  end

  // Control registers
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      first_control_register_r  <= `TMR16_CTL_RST;
      second_control_register_r <= `TMR16_CTL_RST;
    end else if (wr_stb) begin
      if (addr == `TMR16_CTL1_OFS)
        first_control_register_r <= wr_data;
      if (addr == `TMR16_CTL2_OFS)
        second_control_register_r <= wr_data;
    end
  end

  // Coherent 16-bit read: first high read buffers the low byte
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      seq_open_r <= 1'b0;
      low_buf_r  <= 8'h00;
    end else if (high_rd) begin
      if (!seq_open_r) begin
        seq_open_r <= 1'b1;
        low_buf_r  <= count_value[7:0];
      end
    end else if (low_rd) begin
      seq_open_r <= 1'b0;
    end
  end

  // Overflow flag, set beats clear
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      overflow_flag_r <= 1'b0;
      ovf_arm_r       <= 1'b0;
    end else begin
      if (stat_rd && overflow_flag_r)
        ovf_arm_r <= 1'b1;
      else if (cntl_acc)
        ovf_arm_r <= 1'b0;
      // Alternate low access never reaches the clear
      if (roll)
        overflow_flag_r <= 1'b1;
      else if (cntl_acc && ovf_arm_r)
        overflow_flag_r <= 1'b0;
    end
  end

  // Capture channels
  assign cap_pin       = {capture_pin_two, capture_pin_one};
  assign cap_edge[0]   = first_control_register_r[`TMR16_CTL1_EDGE1];
  assign cap_edge[1]   = second_control_register_r[`TMR16_CTL2_EDGE2];
  assign cap_on[0]     = ~pwm_or_opm;
  assign cap_on[1]     = (FLASH_TIMER_A == 0);
  assign cap_hi_ofs[0] = `TMR16_IC1H_OFS;
  assign cap_lo_ofs[0] = `TMR16_IC1L_OFS;
  assign cap_hi_ofs[1] = `TMR16_IC2H_OFS;
  assign cap_lo_ofs[1] = `TMR16_IC2L_OFS;

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : g_cap
      tmr16_capture u_cap (
        .clk       (clk),
        .rst_n     (rst_n),
        .cap_pin   (cap_pin[ch]),
        .edge_rise (cap_edge[ch]),
        .chan_on   (cap_on[ch]),
        .cnt_val   (count_value),
        .stat_rd   (stat_rd),
        .hi_rd     (rd_stb && (addr == cap_hi_ofs[ch])),
        .lo_rd     (rd_stb && (addr == cap_lo_ofs[ch])),
        .lo_acc    ((rd_stb | wr_stb) && (addr == cap_lo_ofs[ch])),
        .cap_val_r (cap_val[ch]),
        .flag_r    (cap_flag[ch])
      );
    end
  endgenerate

  // Compare flags live elsewhere and read zero here
  assign status = {cap_flag[0], 1'b0, overflow_flag_r,
                   cap_flag[1] & cap_on[1], 1'b0, 3'h0};

  // Read mux; unmapped offsets read zero
  always @* begin
    case (addr)
      `TMR16_CTL1_OFS:  rd_nxt = first_control_register_r;
      `TMR16_CTL2_OFS:  rd_nxt = second_control_register_r;
      `TMR16_STAT_OFS:  rd_nxt = status;
      `TMR16_CNTH_OFS,
      `TMR16_ACNTH_OFS: rd_nxt = count_value[15:8];
      `TMR16_CNTL_OFS,
      `TMR16_ACNTL_OFS: rd_nxt = seq_open_r ? low_buf_r
                                : count_value[7:0];
      `TMR16_IC1H_OFS:  rd_nxt = cap_val[0][15:8];
      `TMR16_IC1L_OFS:  rd_nxt = cap_val[0][7:0];
      `TMR16_IC2H_OFS:  rd_nxt = cap_on[1] ? cap_val[1][15:8]
                                : 8'h00;
      `TMR16_IC2L_OFS:  rd_nxt = cap_on[1] ? cap_val[1][7:0]
                                : 8'h00;
      default:          rd_nxt = 8'h00;
    endcase
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      rd_data <= 8'h00;
    else if (rd_stb)
      rd_data <= rd_nxt;
  end

  // Sticky flags keep a masked request pending
  assign irq_nxt = ~cpu_irq_mask &
    ((overflow_flag_r &
      first_control_register_r[`TMR16_CTL1_OVFIE]) |
     (first_control_register_r[`TMR16_CTL1_CAPIE] &
      (status[`TMR16_STAT_CAPF1] | status[`TMR16_STAT_CAPF2])));

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      timer_irq <= 1'b0;
    else
      timer_irq <= irq_nxt;
  end

endmodule

// *** testbench/tcc_properties.sv ***
`timescale 1ns/10ps
module tcc_properties (
  // Clock and reset
  input wire        clk,
  input wire        rst_n,
  // Register port
  input wire [7:0]  addr,
  input wire        wr_stb,
  input wire        rd_stb,
  input wire [7:0]  rd_data,
  // CPU state and results
  input wire        cpu_irq_mask,
  input wire        halt_mode,
  input wire        timer_irq,
  input wire [15:0] count_value
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_reset_load: assert property ($rose(rst_n) |-> count_value == 16'hfffc)
    else $error("count not at reload value after reset");
  a_low_reload: assert property (
    wr_stb && (addr == 8'h09 || addr == 8'h0b) |=> count_value == 16'hfffc)
    else $error("low byte write did not reload count");
  a_count_step: assert property (
    $changed(count_value) && !$past(wr_stb)
    |-> (count_value - $past(count_value)) == 16'h0001)
    else $error("count moved by other than one");
  // Fastest tick is every second edge, so no two steps in a row
  a_single_tick: assert property (
    $changed(count_value) && !$past(wr_stb) && !wr_stb
    |=> $stable(count_value))
    else $error("count stepped on two edges in a row");
  a_halt_hold: assert property (
    halt_mode && $past(halt_mode) && $past(halt_mode, 2) && !$past(wr_stb)
    |-> $stable(count_value))
    else $error("count moved in halt");
  a_mask_quiet: assert property ($past(cpu_irq_mask) |-> !timer_irq)
    else $error("interrupt raised while masked");
  a_high_main: assert property (
    rd_stb && addr == 8'h08 |=> rd_data == $past(count_value[15:8]))
    else $error("main high byte wrong");
  a_high_alt: assert property (
    rd_stb && addr == 8'h0a |=> rd_data == $past(count_value[15:8]))
    else $error("alternate high byte wrong");
  a_low_buffer: assert property (
    rd_stb && addr == 8'h08 ##1 rd_stb && addr == 8'h09
    |=> rd_data == $past(count_value[7:0], 2))
    else $error("buffered low byte wrong");
endmodule

bind tmr16_top tcc_properties i_tcc_properties (.clk(clk), .rst_n(rst_n),
  .addr(addr), .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data),
  .cpu_irq_mask(cpu_irq_mask), .halt_mode(halt_mode),
  .timer_irq(timer_irq), .count_value(count_value));

// *** testbench/tcc_pins.sv ***
`timescale 1ns/10ps
module tcc_pins (
  // Clock
  input  wire       clk,
  // Pulse request, one bit per pin
  input  wire [2:0] req,
  // Capture one, capture two, external clock
  output reg  [2:0] pin
);
  reg [3:0] hold_r;
  initial begin
    pin = 3'h0;
    hold_r = 4'h0;
  end
  // One pulse at a time keeps active edges six clocks apart
  always @(posedge clk) begin
    if (hold_r != 4'h0) begin
      hold_r <= hold_r - 4'h1;
      if (hold_r == 4'h1)
        pin <= 3'h0;
    end else if (req != 3'h0) begin
      pin <= req;
      hold_r <= 4'h5;
    end
  end
endmodule

// *** testbench/timer16_counter_capture_tb.sv ***
`timescale 1ns/10ps
module timer16_counter_capture_tb;
  reg         clk, rst_n, wr_stb, rd_stb, cpu_irq_mask, halt_mode;
  reg  [7:0]  addr, wr_data, d, dh, dl, h;
  reg  [2:0]  req;
  reg  [15:0] c, c0, cp;
  wire [7:0]  rd_data;
  wire [2:0]  pin;
  wire        timer_irq;
  wire [15:0] count_value;
  integer     error_cnt, tests_run, cyc, i, j, n, seed_v;

  initial clk = 1'b0;
  always #20 clk = ~clk;

  tmr16_top i_tmr16_top (.clk(clk), .rst_n(rst_n), .addr(addr),
    .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data),
    .ext_timer_clock_pin(pin[2]), .capture_pin_one(pin[0]),
    .capture_pin_two(pin[1]), .cpu_irq_mask(cpu_irq_mask),
    .halt_mode(halt_mode), .timer_irq(timer_irq), .count_value(count_value));
  tcc_pins i_tcc_pins (.clk(clk), .req(req), .pin(pin));

  function integer dvf(input integer k);
    dvf = 2 << k;
  endfunction
  function [1:0] ccf(input integer k);
    ccf = (k == 0) ? 2'h1 : (k == 1) ? 2'h0 : 2'h2;
  endfunction

  task chk(input [15:0] s, input [15:0] e);
    tests_run = tests_run + 1;
    if (s !== e) begin
      error_cnt = error_cnt + 1;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task final_report;
    $display("Checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task wr(input [7:0] a, input [7:0] v);
    @(posedge clk); addr <= a; wr_data <= v; wr_stb <= 1'b1;
    @(posedge clk); wr_stb <= 1'b0;
  endtask
  task rd(input [7:0] a, output [7:0] v, output [15:0] cv);
    @(posedge clk); addr <= a; rd_stb <= 1'b1;
    @(posedge clk); rd_stb <= 1'b0; cv = count_value;
    @(posedge clk); v = rd_data;
  endtask
  // High then low with no gap
  task rd2(input [7:0] a, output [7:0] hi, output [7:0] lo,
           output [15:0] cv);
    @(posedge clk); addr <= a; rd_stb <= 1'b1;
    @(posedge clk); cv = count_value; addr <= a + 8'h01;
    @(posedge clk); rd_stb <= 1'b0; hi = rd_data;
    @(posedge clk); lo = rd_data;
  endtask
  task pulse(input [2:0] r);
    @(posedge clk); req <= r; cp = count_value;
    @(posedge clk); req <= 3'h0;
    repeat (12) @(posedge clk);
  endtask

  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      error_cnt = error_cnt + 1;
      final_report;
    end
  end

  initial begin
    rst_n = 1'b0; wr_stb = 1'b0; rd_stb = 1'b0; addr = 8'h00;
    wr_data = 8'h00; req = 3'h0; cpu_irq_mask = 1'b0; halt_mode = 1'b0;
    error_cnt = 0; tests_run = 0; cyc = 0;
    seed_v = $urandom(47);
    repeat (4) @(posedge clk);
    chk(count_value, 16'hfffc);
    rst_n <= 1'b1;
    rd(8'h00, d, c); chk(d, 8'h00);
    rd(8'h01, d, c); chk(d, 8'h00);
    rd(8'h06, d, c); chk(d, 8'h00);
    for (i = 0; i < 16; i = i + 1) begin
      h = ($urandom % 2) ? 8'h0a : 8'h08;
      n = (h == 8'h0a) ? $urandom % 3 : 0;
      for (j = 0; j < n; j = j + 1) begin
        rd(h, d, c); chk(d, c[15:8]);
        if (j == 0) c0 = c;
      end
      rd2(h, dh, dl, c);
      chk(dh, c[15:8]);
      chk(dl, (n != 0) ? c0[7:0] : c[7:0]);
      repeat ($urandom % 4) @(posedge clk);
      rd(h + 8'h01, d, c); chk(d, c[7:0]);
    end
    for (i = 0; i < 3; i = i + 1) begin
      wr(8'h00, {4'h0, ccf(i), 2'h0});
      c = count_value; j = 0;
      while (count_value === c && j < 20) begin
        @(posedge clk); j = j + 1;
      end
      c = count_value;
      repeat (3 * dvf(i)) @(posedge clk);
      chk(count_value, c + 16'h0003);
    end
    halt_mode <= 1'b1;
    repeat (3) @(posedge clk); c = count_value;
    repeat (20) @(posedge clk); chk(count_value, c);
    halt_mode <= 1'b0;
    wr(8'h01, 8'h20); wr(8'h00, 8'h04); wr(8'h09, 8'h00);
    j = 0;
    while (timer_irq !== 1'b1 && j < 40) begin
      @(posedge clk); j = j + 1;
    end
    chk(timer_irq, 1'b1);
    rd(8'h09, d, c); repeat (2) @(posedge clk); chk(timer_irq, 1'b1);
    rd(8'h02, d, c); chk(d & 8'h20, 8'h20);
    cpu_irq_mask <= 1'b1;
    repeat (2) @(posedge clk); chk(timer_irq, 1'b0);
    cpu_irq_mask <= 1'b0;
    repeat (2) @(posedge clk); chk(timer_irq, 1'b1);
    rd(8'h0b, d, c); repeat (2) @(posedge clk); chk(timer_irq, 1'b1);
    rd(8'h09, d, c); repeat (2) @(posedge clk); chk(timer_irq, 1'b0);
    wr(8'h01, 8'h82); wr(8'h00, 8'h06);
    pulse(3'h1);
    rd(8'h02, d, c); chk(d & 8'h80, 8'h80);
    chk(timer_irq, 1'b1);
    c0 = cp;
    rd(8'h03, dh, c); rd(8'h04, dl, c);
    chk({dh, dl} - c0 < 16'h0008, 1'b1);
    rd(8'h02, d, c); chk(d & 8'h80, 8'h00);
    rd(8'h03, dh, c); pulse(3'h1);
    rd(8'h02, d, c); chk(d & 8'h80, 8'h00);
    rd(8'h04, dl, c); pulse(3'h1);
    rd(8'h02, d, c); chk(d & 8'h80, 8'h80);
    rd(8'h04, dl, c);
    wr(8'h00, 8'h24); pulse(3'h1);
    rd(8'h02, d, c); chk(d & 8'h80, 8'h00);
    pulse(3'h2);
    rd(8'h02, d, c); chk(d & 8'h90, 8'h10);
    chk(timer_irq, 1'b1);
    rd(8'h0c, dh, c);
    rd(8'h0d, dl, c);
    chk({dh, dl} - cp < 16'h0010, 1'b1);
    repeat (2) @(posedge clk);
    chk(timer_irq, 1'b0);
    wr(8'h00, 8'h0d);
    repeat (2) @(posedge clk); c = count_value;
    repeat (4) pulse(3'h4);
    chk(count_value, c + 16'h0004);
    // Falling external edges, PWM set so channel one stays idle
    wr(8'h00, 8'h1c);
    c = count_value;
    repeat (2) pulse(3'h4);
    chk(count_value, c + 16'h0002);
    pulse(3'h1);
    rd(8'h02, d, c);
    chk(d & 8'h80, 8'h00);
    final_report;
  end
endmodule
